// ### edge_interrupt_acceptance_test.sv
`timescale 1ns/1ns
`default_nettype none
module edge_interrupt_acceptance_test;
  logic        core_clk = 1'h0;
  logic        arst_n = 1'h0;
  logic [15:0] mem_addr = 16'h0;
  logic [7:0]  mem_wdata = 8'h0;
  logic [7:0]  psw_wdata = 8'h0;
  logic [7:0]  src_req = 8'h0;
  logic [4:0]  st = 5'h0;
  logic [2:0]  pins = 3'h0;
  logic [3:0]  instr_len = 4'h4;
  logic        mem_wr = 1'h0;
  logic        mem_rd = 1'h0;
  logic        watchdog_request = 1'h0;
  logic        touch_req = 1'h0;
  wire         instr_last_clk, instr_touches_flags, svc_busy_q, stack_wr_q, vec_load_q, ack_nmi_q;
  wire  [15:0] cpu_pc, vec_addr_q;
  wire  [7:0]  mem_rdata_q, psw_q, stack_wdata_q, request_flag_q, mask_flag_q;
  wire  [2:0]  ack_src_q;
  integer      miscompares = 0;
  integer      cmp_count = 0;
  eia_cpu_model u_cpu (.core_clk, .arst_n, .svc_busy_q, .touch_req, .instr_len, .instr_last_clk,
    .instr_touches_flags, .cpu_pc);
  eia_ctrl DUT (.core_clk, .arst_n, .mem_addr, .mem_wr, .mem_rd, .mem_wdata, .mem_rdata_q,
    .psw_wr(st[0]), .psw_wdata, .enable_accept_instruction(st[3]), .disable_accept_instruction(st[4]),
    .psw_q, .flag_wr(st[1]), .flag_wdata(psw_wdata), .mask_wr(st[2]), .mask_wdata(psw_wdata),
    .request_flag_q, .mask_flag_q, .ext_request_pin0(pins[0]), .ext_request_pin1(pins[1]),
    .ext_request_pin2(pins[2]), .src_req, .watchdog_request, .instr_last_clk, .instr_touches_flags,
    .cpu_pc, .svc_busy_q, .stack_wr_q, .stack_wdata_q, .vec_load_q, .vec_addr_q, .ack_nmi_q, .ack_src_q);
  initial forever #2 core_clk = ~core_clk;
  task chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // strobe k: 0 status, 1 flags, 2 mask, 3 enable, 4 disable
  task pw(input integer k, input logic [7:0] d);
    psw_wdata = d;
    st = 5'h1 << k;
    @(negedge core_clk);
    st = 5'h0;
    @(negedge core_clk);
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1'h1;
    @(negedge core_clk);
    mem_wr = 1'h0;
    @(negedge core_clk);
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    mem_addr = a;
    mem_rd = 1'h1;
    @(negedge core_clk);
    mem_rd = 1'h0;
    chk(mem_rdata_q, e);
    @(negedge core_clk);
  endtask
  // one acceptance from its first negedge: status push, then vector
  task seq(input logic [7:0] p, input logic [15:0] v, inout integer n);
    @(negedge core_clk);
    n++;
    chk({stack_wr_q, stack_wdata_q}, {1'h1, p});
    repeat (3) @(negedge core_clk);
    n = n + 3;
    chk(vec_addr_q, v);
    chk(vec_load_q, 1'h1);
  endtask
  // bounded wait for busy level, cycles added to n
  task wb(input logic v, inout integer n);
    integer k;
    k = 0;
    while (svc_busy_q !== v && k < 60)
    begin
      @(negedge core_clk);
      n++;
      k++;
    end
  endtask
  task t_regs;
    chk(psw_q, 8'h02);
    chk(request_flag_q, 8'h00);
    chk(mask_flag_q, 8'hff);
    rd(16'hffec, 8'h00);
    wr(16'hffec, 8'hff);
    rd(16'hffec, 8'hfc);
    wr(16'hffed, 8'h55);
    rd(16'hffec, 8'hfc);
    rd(16'hffed, 8'h00);
    $display("regs done");
  endtask
  task t_pin;
    integer p;
    integer c;
    logic [1:0] s;
    for (p = 0; p < 3; p++)
      for (c = 0; c < 3; c++)
      begin
        // pattern 10 is never written; the third pass selects both edges
        s = (c == 2) ? 2'h3 : c[1:0];
        pw(2, 8'hff);
        wr(16'hffec, {6'h0, s} << (2 * p + 2));
        repeat (6) @(negedge core_clk);
        pw(1, 8'h00);
        pins[p] = 1'h1;
        repeat (8) @(negedge core_clk);
        chk(request_flag_q[p+1], s[0]);
        pw(1, 8'h00);
        pins[p] = 1'h0;
        repeat (8) @(negedge core_clk);
        chk(request_flag_q[p+1], s[0] == s[1]);
        pw(1, 8'h00);
      end
    $display("pins done");
  endtask
  task t_mask;
    integer lat;
    pw(2, 8'hdb);
    pw(0, 8'h82);
    while (instr_last_clk !== 1'h1) @(negedge core_clk);
    src_req = 8'h24;
    @(negedge core_clk);
    src_req = 8'h00;
    lat = 1;
    wb(1'h1, lat);
    chk(ack_src_q, 3'h2);
    chk(psw_q, 8'h02);
    seq(8'h82, 16'h0008, lat);
    wb(1'h0, lat);
    chk(lat >= 9 && lat <= 19, 1'h1);
    repeat (20) @(negedge core_clk);
    chk(request_flag_q, 8'h20);
    pw(3, 8'h00);
    wb(1'h1, lat);
    chk(ack_src_q, 3'h5);
    seq(8'h82, 16'h000e, lat);
    wb(1'h0, lat);
    $display("maskable done");
  endtask
  task t_nmi;
    integer n;
    pw(2, 8'hef);
    pw(3, 8'h00);
    src_req = 8'h10;
    watchdog_request = 1'h1;
    @(negedge core_clk);
    src_req = 8'h00;
    watchdog_request = 1'h0;
    n = 0;
    wb(1'h1, n);
    chk(ack_nmi_q, 1'h1);
    watchdog_request = 1'h1;
    @(negedge core_clk);
    watchdog_request = 1'h0;
    wb(1'h0, n);
    wb(1'h1, n);
    chk(ack_nmi_q, 1'h1);
    seq(8'h02, 16'h0004, n);
    wb(1'h0, n);
    chk(request_flag_q, 8'h10);
    $display("nmi done");
  endtask
  task t_hold;
    logic b;
    integer n;
    instr_len = 4'ha;
    // the pending level-4 flag stays masked while the enable toggles
    pw(2, 8'hff);
    pw(3, 8'h00);
    chk(psw_q, 8'h82);
    pw(4, 8'h00);
    chk(psw_q, 8'h02);
    touch_req = 1'h1;
    pw(2, 8'hef);
    pw(3, 8'h00);
    b = 1'h0;
    repeat (30)
    begin
      @(negedge core_clk);
      b = b | svc_busy_q;
    end
    chk(b, 1'h0);
    touch_req = 1'h0;
    n = 0;
    wb(1'h1, n);
    chk(ack_src_q, 3'h4);
    seq(8'h82, 16'h000c, n);
    wb(1'h0, n);
    $display("hold done");
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #40000;
    miscompares++;
    wrap_up;
  end
  initial
  begin
    repeat (8) @(negedge core_clk);
    arst_n = 1'h1;
    repeat (4) @(negedge core_clk);
    t_regs;
    t_pin;
    t_mask;
    t_nmi;
    t_hold;
    wrap_up;
  end
endmodule
bind eia_ctrl eia_ctrl_properties #(.NSRC(NSRC)) u_props (.core_clk, .arst_n, .mem_addr, .mem_rd,
  .mem_rdata_q, .psw_q, .request_flag_q, .mask_flag_q, .instr_last_clk, .instr_touches_flags,
  .svc_busy_q, .stack_wr_q, .stack_wdata_q, .vec_load_q, .vec_addr_q, .ack_nmi_q, .ack_src_q);
`default_nettype wire

// ### eia_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module eia_cpu_model
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // controls
  input  wire logic        svc_busy_q,
  input  wire logic        touch_req,
  input  wire logic [3:0]  instr_len,
  // sequencer
  output var  logic        instr_last_clk,
  output var  logic        instr_touches_flags,
  output var  logic [15:0] cpu_pc
);
  logic [3:0] cnt_q;
  // stalls while acknowledge runs; lengths 4 to 10 clocks
  always @(negedge core_clk or negedge arst_n)
    if (!arst_n)
    begin
      cnt_q <= 4'hf;
      instr_last_clk <= 1'h0;
      instr_touches_flags <= 1'h0;
      cpu_pc <= 16'h0100;
    end
    else if (svc_busy_q)
    begin
      cnt_q <= 4'hf;
      instr_last_clk <= 1'h0;
    end
    else
    begin
      cnt_q <= (cnt_q == instr_len - 4'h1) ? 4'h0 : cnt_q + 4'h1;
      instr_last_clk <= (cnt_q == instr_len - 4'h2);
      instr_touches_flags <= touch_req;
      cpu_pc <= cpu_pc + {15'h0, instr_last_clk};
    end
endmodule
`default_nettype wire

// ### eia_ctrl.v
`timescale 1ns/1ns
`default_nettype none
`include "eia_defines.vh"
module eia_ctrl
#(
  parameter NSRC = 8
)
(
  // clock and reset
  input  wire             core_clk,
  input  wire             arst_n,
  // memory-mapped register access
  input  wire [15:0]      mem_addr,
  input  wire             mem_wr,
  input  wire             mem_rd,
  input  wire [7:0]       mem_wdata,
  output reg  [7:0]       mem_rdata_q,
  // status word access and dedicated instructions
  input  wire             psw_wr,
  input  wire [7:0]       psw_wdata,
  input  wire             enable_accept_instruction,
  input  wire             disable_accept_instruction,
  output reg  [7:0]       psw_q,
  // request and mask flag access
  input  wire             flag_wr,
  input  wire [NSRC-1:0]  flag_wdata,
  input  wire             mask_wr,
  input  wire [NSRC-1:0]  mask_wdata,
  output reg  [NSRC-1:0]  request_flag_q,
  output reg  [NSRC-1:0]  mask_flag_q,
  // request sources
  input  wire             ext_request_pin0,
  input  wire             ext_request_pin1,
  input  wire             ext_request_pin2,
  input  wire [NSRC-1:0]  src_req,
  input  wire             watchdog_request,
  // instruction sequencer handshake
  input  wire             instr_last_clk,
  input  wire             instr_touches_flags,
  input  wire [15:0]      cpu_pc,
  // acknowledge sequence
  output reg              svc_busy_q,
  output reg              stack_wr_q,
  output reg  [7:0]       stack_wdata_q,
  output reg              vec_load_q,
  output reg  [15:0]      vec_addr_q,
  output reg              ack_nmi_q,
  output reg  [2:0]       ack_src_q
);
  localparam ST_IDLE   = 3'h0;
  localparam ST_ACCEPT = 3'h1;
  localparam ST_PSW    = 3'h2;
  localparam ST_PCH    = 3'h3;
  localparam ST_PCL    = 3'h4;
  localparam ST_VEC    = 3'h5;

  reg  [7:0]      edge_sel_q;
  reg             nmi_pend_q;
  reg             hold_q;
  reg  [2:0]      state_q;
  reg  [2:0]      state_d;
  reg  [7:0]      psw_saved_q;
  reg  [15:0]     pc_saved_q;
  reg  [2:0]      win_q;
  reg             win_nmi_q;
  wire [2:0]      pin_hit;
  wire [NSRC-1:0] set_vec;
  wire [NSRC-1:0] eligible;
  wire            any_mask;
  wire [2:0]      prio_idx;
  wire            boundary;
  wire            take;
  wire            take_nmi;
  wire [NSRC-1:0] clr_vec;
  wire [2:0]      pin_bus;
  wire            accept_en;
  wire            take_mask;

  function [15:0] vec_of;
    input [2:0] src;
    begin
      case (src)
        3'h0:    vec_of = `EIA_VEC_SRC0;
        3'h1:    vec_of = `EIA_VEC_SRC1;
        3'h2:    vec_of = `EIA_VEC_SRC2;
        3'h3:    vec_of = `EIA_VEC_SRC3;
        3'h4:    vec_of = `EIA_VEC_SRC4;
        3'h5:    vec_of = `EIA_VEC_SRC5;
        3'h6:    vec_of = `EIA_VEC_SRC6;
        default: vec_of = `EIA_VEC_SRC7;
      endcase
    end
  endfunction

  // register decode, shared by the write and read paths
  function sel_addr_hit;
    input [15:0] addr;
    begin
      sel_addr_hit = (addr == `EIA_EDGE_SEL_ADDR);
    end
  endfunction

  // status word with only the accept enable replaced
  function [7:0] with_ie;
    input [7:0] processor_status_word;
    input       ie;
    begin
      with_ie                  = processor_status_word;
      with_ie[`EIA_PSW_IE_BIT] = ie;
    end
  endfunction

  // edge detectors, one per external pin
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_pin
      eia_pin_edge u_edge
      (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .pin_in     (pin_bus[g]),
        .edge_sel   (edge_sel_q[`EIA_PIN0_SEL_LSB + 2*g +: 2]),
        .edge_hit_q (pin_hit[g])
      );
    end
  endgenerate

  // pins occupy levels 1..3, the rest come from internal sources
  assign set_vec = src_req | ({{(NSRC-4){1'b0}}, pin_hit, 1'b0});

  // pins gathered so the generate loop can index them
  assign pin_bus = {ext_request_pin2, ext_request_pin1, ext_request_pin0};

  // eligible only with flag up, mask down, accept enabled
  assign accept_en = psw_q[`EIA_PSW_IE_BIT];
  assign eligible  = request_flag_q & ~mask_flag_q & {NSRC{accept_en}};

  eia_prio #(.N(NSRC)) u_prio
  (
    .eligible (eligible),
    .any      (any_mask),
    .idx      (prio_idx)
  );

  // flags sampled before this edge, so a flag set in the last clock
  // misses this boundary and waits one more instruction
  // a flag-touching instruction blocks its own and the next boundary
  assign boundary = instr_last_clk & ~instr_touches_flags & ~hold_q & (state_q == ST_IDLE);
  assign take_nmi = boundary & nmi_pend_q;
  assign take     = boundary & (nmi_pend_q | any_mask);
  // a non-maskable win leaves every maskable flag standing
  assign take_mask = take & ~nmi_pend_q;
  assign clr_vec  = take_mask ? ({{(NSRC-1){1'b0}}, 1'b1} << prio_idx) : {NSRC{1'b0}};

  // edge select register, byte access only
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      edge_sel_q  <= `EIA_EDGE_SEL_RST;
      mem_rdata_q <= 8'h00;
    end
    else
    begin
      // pattern 10 is left stored; the detector then ignores the pin
      if (mem_wr && sel_addr_hit(mem_addr))
        edge_sel_q <= mem_wdata & `EIA_EDGE_SEL_WMASK;
      // unmapped reads answer zero
      mem_rdata_q <= (mem_rd && sel_addr_hit(mem_addr)) ? edge_sel_q : 8'h00;
    end
  end

  // status word
  // acceptance beats a byte write so the enable clear is never lost
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      psw_q <= `EIA_PSW_RST;
    else if (take)
      psw_q <= with_ie(psw_q, 1'b0);
    else if (psw_wr)
      psw_q <= psw_wdata;
    else if (enable_accept_instruction)
      psw_q <= with_ie(psw_q, 1'b1);
    else if (disable_accept_instruction)
      psw_q <= with_ie(psw_q, 1'b0);
  end

  // request and mask flags; a new request beats any clear
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      request_flag_q <= `EIA_FLAG_RST;
      mask_flag_q    <= `EIA_MASK_RST;
    end
    else
    begin
      request_flag_q <= ((flag_wr ? flag_wdata : request_flag_q) & ~clr_vec) | set_vec;
      if (mask_wr)
        mask_flag_q <= mask_wdata;
    end
  end

  // non-maskable pending and hold-off
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nmi_pend_q <= 1'b0;
      hold_q     <= 1'b0;
    end
    else
    begin
      nmi_pend_q <= (nmi_pend_q & ~take_nmi) | watchdog_request;
      if (instr_last_clk)
        hold_q <= instr_touches_flags;
    end
  end

  // acknowledge sequencer
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:   if (take) state_d = ST_ACCEPT;
      ST_ACCEPT: state_d = ST_PSW;
      ST_PSW:    state_d = ST_PCH;
      ST_PCH:    state_d = ST_PCL;
      ST_PCL:    state_d = ST_VEC;
      ST_VEC:    state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  // five busy clocks after a shortest instruction give the 9-clock floor;
  // the longest instructions stretch it to the 19-clock ceiling
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q       <= ST_IDLE;
      psw_saved_q   <= 8'h00;
      pc_saved_q    <= 16'h0000;
      win_q         <= 3'h0;
      win_nmi_q     <= 1'b0;
      svc_busy_q    <= 1'b0;
      stack_wr_q    <= 1'b0;
      stack_wdata_q <= 8'h00;
      vec_load_q    <= 1'b0;
      vec_addr_q    <= 16'h0000;
      ack_nmi_q     <= 1'b0;
      ack_src_q     <= 3'h0;
    end
    else
    begin
      state_q    <= state_d;
      svc_busy_q <= (state_d != ST_IDLE);
      stack_wr_q <= 1'b0;
      vec_load_q <= 1'b0;
      ack_nmi_q  <= 1'b0;
      if (take)
      begin
        // status word captured before its enable is cleared
        psw_saved_q <= psw_q;
        pc_saved_q  <= cpu_pc;
        win_nmi_q   <= nmi_pend_q;
        win_q       <= prio_idx;
        ack_nmi_q   <= nmi_pend_q;
        ack_src_q   <= prio_idx;
      end
      // status word first, then program counter high and low
      case (state_d)
        ST_PSW:
        begin
          stack_wr_q    <= 1'b1;
          stack_wdata_q <= psw_saved_q;
        end
        ST_PCH:
        begin
          stack_wr_q    <= 1'b1;
          stack_wdata_q <= pc_saved_q[15:8];
        end
        ST_PCL:
        begin
          stack_wr_q    <= 1'b1;
          stack_wdata_q <= pc_saved_q[7:0];
        end
        ST_VEC:
        begin
          vec_load_q <= 1'b1;
          vec_addr_q <= win_nmi_q ? `EIA_VEC_NMI : vec_of(win_q);
        end
        default:
          stack_wdata_q <= stack_wdata_q;
      endcase
    end
  end

  // nesting falls out of the enable clear: a service routine must
  // raise acceptance again before anything maskable gets
  // selector changes rely on software masking the pin first
endmodule
`default_nettype wire

// ### eia_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none
module eia_ctrl_properties
#(
  parameter NSRC = 8
)
(
  // clock and reset
  input wire logic            core_clk,
  input wire logic            arst_n,
  // register port
  input wire logic [15:0]     mem_addr,
  input wire logic            mem_rd,
  input wire logic [7:0]      mem_rdata_q,
  // status and flags
  input wire logic [7:0]      psw_q,
  input wire logic [NSRC-1:0] request_flag_q,
  input wire logic [NSRC-1:0] mask_flag_q,
  // sequencer
  input wire logic            instr_last_clk,
  input wire logic            instr_touches_flags,
  // acknowledge
  input wire logic            svc_busy_q,
  input wire logic            stack_wr_q,
  input wire logic [7:0]      stack_wdata_q,
  input wire logic            vec_load_q,
  input wire logic [15:0]     vec_addr_q,
  input wire logic            ack_nmi_q,
  input wire logic [2:0]      ack_src_q
);
  wire [NSRC-1:0] elig = request_flag_q & ~mask_flag_q & {NSRC{psw_q[7]}};
  wire [NSRC-1:0] win  = {{(NSRC-1){1'h0}}, 1'h1} << ack_src_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  AST_SEQ: assert property ($rose(svc_busy_q) |=> stack_wr_q [*3] ##1 vec_load_q ##1 !svc_busy_q)
    else $error("bad acknowledge sequence");
  AST_PUSH: assert property ($rose(svc_busy_q) |=> stack_wdata_q == $past(psw_q, 2))
    else $error("bad status push");
  AST_IE: assert property ($rose(svc_busy_q) |-> !psw_q[7])
    else $error("enable not cleared");
  AST_GATE: assert property ($rose(svc_busy_q) && !ack_nmi_q |-> |($past(elig) & win))
    else $error("ineligible source taken");
  AST_PRIO: assert property ($rose(svc_busy_q) && !ack_nmi_q |-> ($past(elig) & (win - 1'h1)) == '0)
    else $error("lower priority won");
  AST_BND: assert property ($rose(svc_busy_q) |-> $past(instr_last_clk) && !$past(instr_touches_flags))
    else $error("taken off boundary");
  AST_NMI: assert property ($rose(svc_busy_q) && ack_nmi_q |-> ##4 vec_load_q && vec_addr_q == 16'h0004)
    else $error("bad nmi vector");
  AST_RD: assert property (mem_rd && mem_addr != 16'hffec |=> mem_rdata_q == 8'h00)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ### eia_defines.vh
// Summary of operation
// - edge select register at FFECH, 8-bit read/write, resets to 00H.
// - selector 00 falling, 01 rising, 11 both; 10 is never written.
// - pin2 selector bits 7:6, pin1 5:4, pin0 3:2; bits 1:0 read zero.
// - status word resets to 02H, global accept enable cleared.
// - accept enable bit gates maskable acknowledge; byte write, enable and disable instructions.
// - every vectored acknowledge pushes status word and clears accept enable.
// - non-maskable request ignores accept enable and beats every maskable request.
// - acknowledge pushes status word, then program counter, clears enable, loads vector.
// - a second non-maskable request during its service stays pending until the first boundary after that service ends.
// - maskable acknowledge needs request flag 1, mask flag 0, accept enable 1.
// - maskable request to service start takes 9 to 19 clocks.
// - simultaneous eligible maskable requests served highest priority first.
// - a request not yet accepted stays pending until conditions allow.
// - flag set before last clock: acknowledge after current instruction completes.
// - flag set in last clock: one more instruction runs before acknowledge.
// - instruction touching request or mask flags defers acknowledge past next instruction.
// - nesting only when service re-enables acceptance; otherwise request waits.
// - maskable priority levels 0 highest to 7 lowest, fixed per source.
// - request flag sets on source request, clears on acknowledge or reset.
`ifndef EIA_DEFINES_VH
`define EIA_DEFINES_VH

`define EIA_EDGE_SEL_ADDR   16'hffec
`define EIA_EDGE_SEL_RST    8'h00
`define EIA_EDGE_SEL_WMASK  8'hfc
`define EIA_PIN0_SEL_LSB    2
`define EIA_PIN1_SEL_LSB    4
`define EIA_PIN2_SEL_LSB    6

`define EIA_SEL_FALL        2'h0
`define EIA_SEL_RISE        2'h1
`define EIA_SEL_BOTH        2'h3

`define EIA_PSW_RST         8'h02
`define EIA_PSW_IE_BIT      7

`define EIA_FLAG_RST        8'h00
`define EIA_MASK_RST        8'hff
`define EIA_PIN0_SRC        1

`define EIA_VEC_NMI         16'h0004
`define EIA_VEC_SRC0        16'h0004
`define EIA_VEC_SRC1        16'h0006
`define EIA_VEC_SRC2        16'h0008
`define EIA_VEC_SRC3        16'h000a
`define EIA_VEC_SRC4        16'h000c
`define EIA_VEC_SRC5        16'h000e
`define EIA_VEC_SRC6        16'h0014
`define EIA_VEC_SRC7        16'h0016

`define EIA_LAT_MIN_CLKS    9
`define EIA_LAT_MAX_CLKS    19
`define EIA_MIN_INSTR_CLKS  4
`define EIA_SEQ_CLKS        (`EIA_LAT_MIN_CLKS - `EIA_MIN_INSTR_CLKS)

`endif

// ### eia_pin_edge.v
`timescale 1ns/1ns
`default_nettype none
`include "eia_defines.vh"
module eia_pin_edge
(
  // clock and reset
  input  wire       core_clk,
  input  wire       arst_n,
  // pin and selector
  input  wire       pin_in,
  input  wire [1:0] edge_sel,
  // detection
  output reg        edge_hit_q
);
  reg       sync1_q;
  reg       sync2_q;
  reg       prev_q;
  reg [2:0] armed_q;
  wire      rise;
  wire      fall;

  // two stages before any logic looks at the pin
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_q    <= 1'b0;
      sync2_q    <= 1'b0;
      prev_q     <= 1'b0;
      armed_q    <= 3'h0;
      edge_hit_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      // no detection until prev_q holds real pin history,
      // else an idle-high pin fakes a rise right after reset
      armed_q <= {armed_q[1:0], 1'b1};
      case (edge_sel)
        `EIA_SEL_FALL: edge_hit_q <= armed_q[2] & fall;
        `EIA_SEL_RISE: edge_hit_q <= armed_q[2] & rise;
        `EIA_SEL_BOTH: edge_hit_q <= armed_q[2] & (rise | fall);
        default:       edge_hit_q <= 1'b0;
      endcase
    end
  end

  // one pulse per edge since prev_q follows sync2_q
  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;
endmodule
`default_nettype wire

// ### eia_prio.v
`timescale 1ns/1ns
`default_nettype none
module eia_prio
#(
  parameter N = 8
)
(
  // candidates, index 0 highest
  input  wire [N-1:0] eligible,
  // winner
  output reg          any,
  output reg  [2:0]   idx
);
  integer i;

  // scan from lowest level upward so level 0 wins
  always @*
  begin
    any = 1'b0;
    idx = 3'h0;
    for (i = N - 1; i >= 0; i = i - 1)
    begin
      if (eligible[i])
      begin
        any = 1'b1;
        idx = i[2:0];
      end
    end
  end
endmodule
`default_nettype wire
